// ---- include/sbfc_pkg.sv ----
package sbfc_pkg;

    // Command word layout: data byte high, address and code low
    localparam int          CMD_CODE_LSB  = 0;
    localparam int          CMD_ADDR_LSB  = 4;
    localparam int          CMD_DATA_LSB  = 8;

    localparam logic [3:0]  CMD_REQ_ID    = 4'h4;
    localparam logic [3:0]  CMD_CLEAR     = 4'h7;
    localparam logic [3:0]  CMD_FMT_CTRL  = 4'ha;
    localparam logic [3:0]  ADDR_GLOBAL   = 4'h0;

    // Format register pointers
    localparam logic [2:0]  PTR_TAPS      = 3'h0;
    localparam logic [2:0]  PTR_SEED      = 3'h2;
    localparam logic [2:0]  PTR_SW_LEN    = 3'h5;
    localparam logic [2:0]  PTR_FMT_SEL   = 3'h7;

    // Standard framing values
    localparam logic [3:0]  STD_TAPS      = 4'h1;
    localparam logic [3:0]  STD_SEED      = 4'ha;
    localparam logic [3:0]  STD_SW_LEN    = 4'h8;
    localparam logic [3:0]  ALT_SW_LEN    = 4'ha;
    localparam logic [3:0]  FMT_SEL_OFF   = 4'h0;
    localparam logic [3:0]  FMT_SEL_ON    = 4'hf;

    // AXI4-Lite register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_FORMAT    = 8'h08;

    // CTRL fields
    localparam int          CTRL_ADDR_LSB = 0;
    localparam int          CTRL_SW_BIT   = 4;
    localparam logic [3:0]  NODE_ADDR_RST = 4'h0;

    // STATUS fields
    localparam int          STAT_ENH_BIT  = 0;
    localparam int          STAT_FPE_BIT  = 1;
    localparam int          STAT_SW_BIT   = 2;
    localparam int          STAT_VER_LSB  = 4;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] sw_len;
        logic [3:0] seed;
        logic [3:0] taps;
    } sbfc_fmt_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] ptr;
        logic [3:0] data;
    } sbfc_fc_byte_t;

    localparam sbfc_fmt_t   FMT_STD       = '{FMT_SEL_OFF, STD_SW_LEN,
                                              STD_SEED, STD_TAPS};

endpackage : sbfc_pkg

// ---- verilog/sbfc_top.sv ----
`timescale 1ns/10ps
// Overview of operation
// - ID response carries a 4-bit version; its lowest bit is fixed zero.
// - At power-up compare fuse parity with stored parity; flag mismatch.
// - Accepted clear opens the bus switch and resets node address, format registers and pending answer.
// - Clear commands never produce a response, in any word type.
// - Clear acts on matching node address or on the all-zero address.
// - Format control response goes out in the next bus message.
// - Format control accepted only as long word; no short-word response.
// - After reset or clear, standard framing: 8 bits, taps 0001, seed 1010.
// - Format values take effect once one write sets all four selection bits.
// - Standard framing returns only on reset, on clear, or when one write clears all four bits.
// - In enhanced mode ignore format changes except clearing the selection.
// - Data byte: write flag, 3-bit pointer, 4-bit data; code, address low.
// - Write flag one stores the data into the pointed register.
// - Write flag zero leaves the register and reports its contents.
// - Reserved pointers accept nothing; writes to them report zero data.
// - Response: address, four zeros, write flag, pointer, data.
// - Other nonzero addresses: command ignored, no change, no response.
// - Global address format control executes fully but sends no response.
// - Pointer 0 taps, 2 seed, 5 short length, 7 selection; others reserved.
// - Short-word length takes only 8 or 10; other writes are ignored.
// - Taps bits are x^3 down to x^0 with x^4 implied.
// - Seed loads into the CRC checking register before each transaction.
module sbfc_top
    import sbfc_pkg::*;
#(
    parameter logic [3:0] ID_VERSION = 4'h6  // Arbitrary value
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_long_word,
    input  wire logic [15:0] cmd_word,
    input  wire logic        msg_start,
    input  wire logic [7:0]  fuse_state,
    input  wire logic        fuse_parity_stored,
    output logic             rsp_valid,
    output logic [15:0]      rsp_word,
    output sbfc_fmt_t        fmt_active,
    output logic             enhanced,
    output logic [3:0]       crc_check,
    output logic             bus_switch_closed,
    output logic             fuse_parity_error
);

    logic [3:0]    node_addr_q;
    logic          switch_q;
    sbfc_fmt_t     fmt_q;
    logic          fpe_q;
    logic          fuse_done_q;
    logic          pend_q;
    logic [15:0]   pend_word_q;

    logic [3:0]    c_code;
    logic [3:0]    c_addr;
    sbfc_fc_byte_t c_fc;
    logic          hit;
    logic          glob;
    logic          do_clear;
    logic          do_fc;
    logic          do_id;
    logic          fc_rsp;
    logic [3:0]    fc_rd;
    logic [3:0]    fc_echo;
    logic          in_enh;
    logic [15:0]   fc_word;
    logic [15:0]   id_word;

    assign c_code  = cmd_word[CMD_CODE_LSB +: 4];
    assign c_addr  = cmd_word[CMD_ADDR_LSB +: 4];
    assign c_fc    = sbfc_fc_byte_t'(cmd_word[CMD_DATA_LSB +: 8]);
    assign hit     = (c_addr == node_addr_q);
    assign glob    = (c_addr == ADDR_GLOBAL);
    assign in_enh  = (fmt_q.sel == FMT_SEL_ON);

    // Clear on any word type
    assign do_clear = cmd_valid && c_code == CMD_CLEAR && (hit || glob);
    // Long word only; foreign address drops everything
    assign do_fc    = cmd_valid && cmd_long_word && c_code == CMD_FMT_CTRL
                      && (hit || glob);
    assign do_id    = cmd_valid && cmd_long_word && c_code == CMD_REQ_ID
                      && hit && !glob;
    assign fc_rsp   = do_fc && !glob;

    // Answer words
    assign fc_word  = {c_addr, 4'h0, c_fc.wr, c_fc.ptr,
                       c_fc.wr ? fc_echo : fc_rd};
    assign id_word  = {c_addr, 4'h0, ID_VERSION[3:1], 1'b0,
                       3'b000, fpe_q};

    always_comb begin
        case (c_fc.ptr)
            PTR_TAPS:    fc_rd = fmt_q.taps;
            PTR_SEED:    fc_rd = fmt_q.seed;
            PTR_SW_LEN:  fc_rd = fmt_q.sw_len;
            PTR_FMT_SEL: fc_rd = fmt_q.sel;
            default:     fc_rd = 4'h0;
        endcase
    end

    always_comb begin
        case (c_fc.ptr)
            PTR_TAPS, PTR_SEED, PTR_SW_LEN, PTR_FMT_SEL: fc_echo = c_fc.data;
            default:     fc_echo = 4'h0;
        endcase
    end

    // Format registers
    always_ff @(posedge aclk) begin
        if (!aresetn || do_clear) begin
            fmt_q <= FMT_STD;
        end else if (do_fc && c_fc.wr) begin
            case (c_fc.ptr)
                PTR_TAPS: begin
                    if (!in_enh) fmt_q.taps <= c_fc.data;
                end
                PTR_SEED: begin
                    if (!in_enh) fmt_q.seed <= c_fc.data;
                end
                PTR_SW_LEN: begin
                    if (!in_enh && (c_fc.data == STD_SW_LEN
                                    || c_fc.data == ALT_SW_LEN)) begin
                        fmt_q.sw_len <= c_fc.data;
                    end
                end
                PTR_FMT_SEL: begin
                    if (!in_enh && c_fc.data == FMT_SEL_ON) begin
                        fmt_q.sel <= FMT_SEL_ON;
                    end else if (in_enh && c_fc.data == FMT_SEL_OFF) begin
                        fmt_q.sel <= FMT_SEL_OFF;
                    end
                end
                default: begin
                    fmt_q <= fmt_q;
                end
            endcase
        end
    end

    // Framing in force
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt_active <= FMT_STD;
        end else begin
            fmt_active <= in_enh ? fmt_q : FMT_STD;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enhanced <= 1'b0;
        end else begin
            enhanced <= in_enh;
        end
    end

    // CRC preload at each message start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_check <= STD_SEED;
        end else if (msg_start) begin
            crc_check <= in_enh ? fmt_q.seed : STD_SEED;
        end
    end

    // Answer stands for the whole message
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_valid <= 1'b0;
            rsp_word  <= 16'h0000;
        end else if (msg_start) begin
            rsp_valid <= pend_q;
            rsp_word  <= pend_q ? pend_word_q : 16'h0000;
        end
    end

    // Pending answer, sent in the following message
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
        end else if (do_clear) begin
            pend_q <= 1'b0;
        end else if (fc_rsp || do_id) begin
            pend_q <= 1'b1;
        end else if (msg_start) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_word_q <= 16'h0000;
        end else if (fc_rsp) begin
            pend_word_q <= fc_word;
        end else if (do_id) begin
            pend_word_q <= id_word;
        end
    end

    // Power-up fuse parity check, taken once after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fpe_q       <= 1'b0;
            fuse_done_q <= 1'b0;
        end else if (!fuse_done_q) begin
            fpe_q       <= (^fuse_state) ^ fuse_parity_stored;
            fuse_done_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_parity_error <= 1'b0;
        end else begin
            fuse_parity_error <= fpe_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_switch_closed <= 1'b0;
        end else begin
            bus_switch_closed <= switch_q && !do_clear;
        end
    end

    // AXI4-Lite write path
    logic [7:0]  aw_addr_q;
    logic        aw_hold_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_hold_q;
    logic        wr_fire;
    logic        ctrl_wr;

    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign ctrl_wr = wr_fire && aw_addr_q == REG_CTRL && w_strb_q[0];

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == REG_CTRL) ? RESP_OKAY
                                                    : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Node address; clear takes priority
    always_ff @(posedge aclk) begin
        if (!aresetn || do_clear) begin
            node_addr_q <= NODE_ADDR_RST;
        end else if (ctrl_wr) begin
            node_addr_q <= w_data_q[CTRL_ADDR_LSB +: 4];
        end
    end

    // Bus switch opens on clear
    always_ff @(posedge aclk) begin
        if (!aresetn || do_clear) begin
            switch_q <= 1'b0;
        end else if (ctrl_wr) begin
            switch_q <= w_data_q[CTRL_SW_BIT];
        end
    end

    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    // Read data select
    always_comb begin
        rd_resp = RESP_OKAY;
        case (s_axi_araddr)
            REG_CTRL:   rd_word = {27'h0, switch_q, node_addr_q};
            REG_STATUS: rd_word = {24'h0, ID_VERSION[3:1], 1'b0,
                                   1'b0, switch_q, fpe_q, in_enh};
            REG_FORMAT: rd_word = {16'h0, fmt_q};
            default: begin
                rd_word = 32'h0000_0000;
                rd_resp = RESP_SLVERR;
            end
        endcase
    end

    // AXI4-Lite read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
        end
    end

endmodule : sbfc_top

// ---- dv/sbfc_top_monitor.sv ----
`timescale 1ns/10ps
module sbfc_top_monitor
    import sbfc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cmd_valid,
    input wire logic        cmd_long_word,
    input wire logic [15:0] cmd_word,
    input wire logic        msg_start,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_word,
    input wire sbfc_fmt_t   fmt_active,
    input wire logic        enhanced,
    input wire logic [3:0]  crc_check,
    input wire logic        bus_switch_closed,
    input wire logic        fuse_parity_error
);
    sbfc_fmt_t fmt_q;
    always_ff @(posedge aclk) fmt_q <= fmt_active;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rsp_msg: assert property ($rose(rsp_valid) |-> $past(msg_start))
        else $error("answer outside message start");
    chk_rsp_shape: assert property (rsp_valid |->
        rsp_word[15:12] != ADDR_GLOBAL && rsp_word[11:8] == 4'h0)
        else $error("bad answer layout");
    chk_std_view: assert property (!enhanced |-> fmt_active == FMT_STD)
        else $error("standard framing not in force");
    chk_sel_mode: assert property (
        enhanced == (fmt_active.sel == FMT_SEL_ON))
        else $error("mode and selection differ");
    chk_enh_entry: assert property ($rose(enhanced) |->
        $past(cmd_valid, 2) && $past(cmd_long_word, 2) &&
        $past(cmd_word, 2) ==? 16'hff?a)
        else $error("enhanced entered without full set");
    chk_enh_exit: assert property ($fell(enhanced) |->
        $past(cmd_valid, 2) && $past(cmd_word, 2) ==? 16'hf0?a ||
        $past(cmd_valid) && $past(cmd_word) ==? 16'h???7 ||
        $past(cmd_valid, 2) && $past(cmd_word, 2) ==? 16'h???7)
        else $error("enhanced left without full clear");
    chk_seed_load: assert property (
        $past(msg_start) |-> crc_check == fmt_q.seed)
        else $error("seed not loaded at message start");
    chk_clear_open: assert property (
        cmd_valid && cmd_word ==? 16'h??07 |->
        ##[1:2] (!enhanced && !bus_switch_closed))
        else $error("clear did not restore state");
    chk_fuse_hold: assert property (
        $past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn) |->
        $stable(fuse_parity_error))
        else $error("fuse flag changed after power-up");
    cov_enh: cover property ($rose(enhanced));
    cov_rsp: cover property ($rose(rsp_valid));
    cov_clr: cover property (cmd_valid && cmd_word ==? 16'h??07);
endmodule : sbfc_top_monitor
bind sbfc_top sbfc_top_monitor i_sbfc_top_monitor (.*);

// ---- dv/sbfc_bus_master_model.sv ----
`timescale 1ns/10ps
module sbfc_bus_master_model
    import sbfc_pkg::*;
(
    input  wire logic        aclk,
    output logic             cmd_valid,
    output logic             cmd_long_word,
    output logic [15:0]      cmd_word,
    output logic             msg_start,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_word
);
    initial begin
        cmd_valid = 1'b0;
        cmd_long_word = 1'b0;
        cmd_word = 16'h0000;
        msg_start = 1'b0;
    end
    task automatic send(input logic lw, input logic [15:0] w);
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_long_word <= lw;
        cmd_word <= w;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        cmd_word <= ~w;
    endtask : send
    // Answer is collected in the following message
    task automatic msg(output logic v, output logic [15:0] w);
        @(posedge aclk);
        msg_start <= 1'b1;
        @(posedge aclk);
        msg_start <= 1'b0;
        #1;
        v = rsp_valid;
        w = rsp_word;
    endtask : msg
endmodule : sbfc_bus_master_model

// ---- dv/sensor_bus_format_control_tb_top.sv ----
`timescale 1ns/10ps
module sensor_bus_format_control_tb_top
    import sbfc_pkg::*;
;
    logic        aclk, aresetn, cmd_valid, cmd_long_word, msg_start;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, fuse_parity_stored, rsp_valid;
    logic        enhanced, bus_switch_closed, fuse_parity_error, v;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, fuse_state;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, crc_check;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] cmd_word, rsp_word, w;
    sbfc_fmt_t   fmt_active;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // Version bit 0 set on purpose: the design must force it low
    sbfc_top #(.ID_VERSION(4'h7)) i_sbfc_top (.*);
    sbfc_bus_master_model i_mst (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input logic c, input string m);
        n_tests++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic fc(input logic lw, input logic [3:0] a,
                      input logic [7:0] b);
        i_mst.send(lw, {b, a, CMD_FMT_CTRL});
        @(posedge aclk);
        i_mst.msg(v, w);
    endtask : fc
    task automatic t_reset();
        chk(fmt_active === FMT_STD && crc_check === STD_SEED, "std");
        chk(enhanced === 1'b0 && fuse_parity_error === 1'b1, "fuse");
        axi_wr(REG_CTRL, 32'h13);
        chk(r === RESP_OKAY, "ctrl resp");
        axi_rd(REG_STATUS);
        chk(rd[7:4] === 4'h6 && rd[1] === 1'b1, "status");
        chk(bus_switch_closed === 1'b1 && r === RESP_OKAY, "ctrl");
        axi_rd(8'h0c);
        chk(r === RESP_SLVERR && rd === 32'h0, "unmapped");
        i_mst.send(1'b1, {8'h00, 4'h3, CMD_REQ_ID});
        i_mst.msg(v, w);
        chk(v === 1'b1 && w === 16'h3061, "id");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_fc_rw();
        logic [15:0] tbl [10] = '{16'h8383, 16'h0303, 16'h9f90, 16'h4040,
            16'hd9d9, 16'h5058, 16'hdada, 16'h505a, 16'ha5a5, 16'h2025};
        foreach (tbl[i]) begin
            fc(1'b1, 4'h3, tbl[i][15:8]);
            chk(v === 1'b1 && w[15:8] === 8'h30, "fc addr");
            chk(w[7:0] === tbl[i][7:0], "fc data");
        end
        chk(enhanced === 1'b0 && fmt_active === FMT_STD, "held");
        $display("t_fc_rw done");
    endtask : t_fc_rw
    task automatic t_enh();
        fc(1'b1, 4'h3, 8'hf7);
        chk(w === 16'h30f7 && enhanced === 1'b0, "partial set");
        fc(1'b1, 4'h3, 8'hff);
        chk(enhanced === 1'b1 && fmt_active === 16'hfa53, "enter");
        chk(crc_check === 4'h5, "seed");
        fc(1'b1, 4'h3, 8'h81);
        fc(1'b1, 4'h3, 8'hf8);
        chk(enhanced === 1'b1 && fmt_active === 16'hfa53, "lock");
        axi_rd(REG_FORMAT);
        chk(rd === 32'h0000_fa53 && r === RESP_OKAY, "format");
        fc(1'b1, 4'h0, 8'hf0);
        chk(v === 1'b0 && fmt_active === FMT_STD, "exit");
        chk(crc_check === STD_SEED, "seed std");
        fc(1'b0, 4'h3, 8'hff);
        chk(v === 1'b0 && enhanced === 1'b0, "short");
        fc(1'b1, 4'h5, 8'hff);
        chk(v === 1'b0 && enhanced === 1'b0, "foreign");
        $display("t_enh done");
    endtask : t_enh
    task automatic t_clear();
        i_mst.send(1'b1, {8'h00, 4'h3, CMD_REQ_ID});
        i_mst.send(1'b0, {8'h00, ADDR_GLOBAL, CMD_CLEAR});
        i_mst.msg(v, w);
        chk(v === 1'b0 && bus_switch_closed === 1'b0, "global");
        axi_wr(REG_CTRL, 32'h13);
        fc(1'b1, 4'h3, 8'hff);
        chk(enhanced === 1'b1, "again");
        i_mst.send(1'b0, {8'h00, 4'h3, CMD_CLEAR});
        i_mst.msg(v, w);
        chk(v === 1'b0 && fmt_active === FMT_STD, "clear");
        axi_wr(REG_CTRL, 32'h03);
        fc(1'b1, 4'h3, 8'h00);
        chk(w === 16'h3001, "taps");
        $display("t_clear done");
    endtask : t_clear
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, fuse_parity_stored} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        fuse_state = 8'h01;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_reset();
        t_fc_rw();
        t_enh();
        t_clear();
        stop_test();
    end
endmodule : sensor_bus_format_control_tb_top
